// >>> logic/asp_ctrl.sv
// Host-side controller driving an asynchronous 128K x 8 static memory
// Summary of operation
// - Write: active-low select low, strobe low, active-high select high.
// - Read: active-low select and output enable low, strobe and select high.
// - Write spans overlap of both selects and strobe; any release ends it.
// - Address must be valid no later than selects becoming active.
// - Controller must not drive data while memory still drives it.
// - Selects active at least 45 ns or 60 ns before write end.
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_ctrl
   import asp_pkg::*;
#(
   parameter bit SLOW_GRADE = 1'b0,
   parameter int ADDR_W = `ASP_ADDR_W,
   parameter int DATA_W = `ASP_DATA_W
) (
   input wire logic clk_i,                  // 250 MHz clock
   input wire logic reset_i,                // Synchronous reset, high
   input wire logic req_valid_i,            // Access request
   input wire logic req_write_i,            // 1 write, 0 read
   input wire logic [ADDR_W-1:0] req_addr_i, // Byte address
   input wire logic [DATA_W-1:0] req_wdata_i, // Write byte
   output logic req_ready_o,                // Request accepted when high
   output logic rsp_valid_o,                // One-cycle completion pulse
   output logic [DATA_W-1:0] rsp_rdata_o,   // Read byte
   output logic [ADDR_W-1:0] mem_addr_o,    // Address pins
   output logic mem_sel_n_o,                // Active-low select pin
   output logic mem_sel_o,                  // Active-high select pin
   output logic mem_out_en_n_o,             // Output enable pin
   output logic mem_wr_n_o,                 // Write strobe pin
   input wire logic [DATA_W-1:0] mem_data_i, // Data pins, in
   output logic [DATA_W-1:0] mem_data_o,    // Data pins, out
   output logic mem_data_oe_o               // High while driving data
);
   // Cycle counts per speed grade, least times rounded up
   localparam int RD_CYC = SLOW_GRADE ? `ASP_CYC_UP(`ASP_T_AA_SLOW_NS)
                                       : `ASP_CYC_UP(`ASP_T_AA_FAST_NS);
   localparam int WR_CYC0 = SLOW_GRADE ? `ASP_CYC_UP(`ASP_T_PWE_SLOW_NS)
                                        : `ASP_CYC_UP(`ASP_T_PWE_FAST_NS);
   localparam int SCE_CYC = SLOW_GRADE ? `ASP_CYC_UP(`ASP_T_SCE_SLOW_NS)
                                        : `ASP_CYC_UP(`ASP_T_SCE_FAST_NS);
   localparam int WR_CYC = (WR_CYC0 > SCE_CYC) ? WR_CYC0 : SCE_CYC;
   localparam int RC_CYC = SLOW_GRADE ? `ASP_CYC_UP(`ASP_T_RC_SLOW_NS)
                                       : `ASP_CYC_UP(`ASP_T_RC_FAST_NS);
   localparam int HZ_CYC = SLOW_GRADE ? `ASP_CYC_UP(`ASP_T_HZOE_SLOW_NS)
                                       : `ASP_CYC_UP(`ASP_T_HZOE_FAST_NS);
   // Three synchroniser stages plus output register add to the read wait
   localparam int RD_WAIT = RD_CYC + 4;
   localparam int GAP0 = RC_CYC - WR_CYC - 1;
   localparam int GAP_CYC = (GAP0 > HZ_CYC) ? GAP0 : HZ_CYC;
   localparam int CNT_W = 8;
   // At 4 ns a fast read holds the selects for 18 cycles and answers on
   // the 19th edge after the take; a fast write holds the strobe low for
   // 12 cycles, 48 ns against the 45 ns least pulse, and answers on the
   // 14th. The gap after each access covers the output turn-off time, so
   // a write that follows a read never drives into a byte still leaving
   // the memory. Rounding every figure up to whole cycles costs a few
   // cycles per access; that is the price of one clock and no delay line.
   // The slow grade stretches each count the same way: reads answer on
   // the 23rd edge, writes on the 17th.

   asp_state_type state;
   asp_state_type next_state;
   asp_ctrl_type ctrl;
   asp_ctrl_type next_ctrl;
   asp_req_type req;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [DATA_W-1:0] rd_sync;

   // Pin data settle through three stages before use; the memory output
   // is not timed to this clock, so a byte caught mid-change must not pass
   asp_sync #(
      .WIDTH(DATA_W)
   ) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(mem_data_i),
      .q_o(rd_sync)
   );

   // A request is taken only while idle, since ready is low otherwise
   wire logic take = req_ready_o && req_valid_i;
   wire logic cnt_done = (cnt == '0);
   // End-of-access decodes shared by the answer logic
   wire logic rd_done = (state == ST_RD) && cnt_done;
   wire logic wr_done = (state == ST_WR) && cnt_done && req.write;
   wire logic [CNT_W-1:0] rd_load = CNT_W'(RD_WAIT - 1);
   wire logic [CNT_W-1:0] wr_load = CNT_W'(WR_CYC - 1);
   wire logic [CNT_W-1:0] gap_load = CNT_W'(GAP_CYC - 1);

   // Sequencer: address settles with selects, strobes timed by counter
   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_cnt = cnt_done ? cnt : cnt - CNT_W'(1);
      unique case (state)
         ST_IDLE: begin
            if (take && !req_write_i) begin
               next_state = ST_RD;
               next_cnt = rd_load;
               // Address registered in the same edge as selects
               next_ctrl = '{sel_n: 1'b0, sel: 1'b1, out_en_n: 1'b0,
                             wr_n: 1'b1};
            end else if (take) begin
               // Selects and address first, strobe one cycle later
               next_state = ST_WR_SETUP;
               next_ctrl = '{sel_n: 1'b0, sel: 1'b1, out_en_n: 1'b1,
                             wr_n: 1'b1};
            end
         end
         ST_RD: begin
            if (cnt_done) begin
               next_state = ST_GAP;
               next_cnt = gap_load;
               // Deselect lets the memory power down and float
               next_ctrl = '{sel_n: 1'b1, sel: 1'b0, out_en_n: 1'b1,
                             wr_n: 1'b1};
            end
         end
         ST_WR_SETUP: begin
            // Strobe falls a cycle after the selects, address already settled
            next_state = ST_WR;
            next_cnt = wr_load;
            next_ctrl.wr_n = 1'b0;
         end
         ST_WR: begin
            if (cnt_done) begin
               // Strobe and both selects release together; memory stays floating
               next_state = ST_GAP;
               next_cnt = gap_load;
               next_ctrl = '{sel_n: 1'b1, sel: 1'b0, out_en_n: 1'b1,
                             wr_n: 1'b1};
            end
         end
         ST_GAP: begin
            // Recovery keeps accesses a full cycle time apart
            if (cnt_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            // Unused state codes fall back to idle
            next_state = ST_IDLE;
         end
      endcase
   end

   // State, counter and pin controls
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         cnt <= '0;
         ctrl <= '{sel_n: 1'b1, sel: 1'b0, out_en_n: 1'b1, wr_n: 1'b1};
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         ctrl <= next_ctrl;
      end
   end

   // Request capture; address held for the whole access
   // These flops also drive the address and write byte pins
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         req <= '0;
      end else if (take) begin
         req <= '{addr: req_addr_i, wdata: req_wdata_i,
                  write: req_write_i};
      end
   end

   // Handshake and read return; ready comes from the next state so it
   // rises in the very cycle the recovery gap ends
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         req_ready_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= '0;
      end else begin
         req_ready_o <= (next_state == ST_IDLE) && !take;
         rsp_valid_o <= 1'b0;
         if (rd_done) begin
            // Sampled after access time plus synchroniser
            rsp_rdata_o <= rd_sync;
            rsp_valid_o <= 1'b1;
         end else if (wr_done) begin
            rsp_valid_o <= 1'b1;
         end
      end
   end

   // Data driven only while the strobe is low, never while reading
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mem_data_oe_o <= 1'b0;
      end else begin
         mem_data_oe_o <= (next_state == ST_WR);
      end
   end

   // Address and write byte come from the captured request flops, so they
   // stand unchanged from the select edge to the deselect edge
   assign mem_addr_o = req.addr;
   assign mem_data_o = req.wdata;
   assign mem_sel_n_o = ctrl.sel_n;
   assign mem_sel_o = ctrl.sel;
   assign mem_out_en_n_o = ctrl.out_en_n;
   assign mem_wr_n_o = ctrl.wr_n;
endmodule // asp_ctrl

// >>> logic/asp_defs.svh
// Timing and width constants for the static memory port controller
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_CLK_PERIOD_PS 4000
`define ASP_ADDR_W 17
`define ASP_DATA_W 8
// Fast grade figures in ns
`define ASP_T_RC_FAST_NS 55
`define ASP_T_AA_FAST_NS 55
`define ASP_T_SCE_FAST_NS 45
`define ASP_T_PWE_FAST_NS 45
`define ASP_T_SD_FAST_NS 25
`define ASP_T_HZOE_FAST_NS 20
// Slow grade figures in ns
`define ASP_T_RC_SLOW_NS 70
`define ASP_T_AA_SLOW_NS 70
`define ASP_T_SCE_SLOW_NS 60
`define ASP_T_PWE_SLOW_NS 50
`define ASP_T_SD_SLOW_NS 30
`define ASP_T_HZOE_SLOW_NS 25
// Least times round up to whole cycles
`define ASP_CYC_UP(ns) (((ns) * 1000 + `ASP_CLK_PERIOD_PS - 1) / `ASP_CLK_PERIOD_PS)
`endif

// >>> logic/asp_pkg.sv
// Types shared by the static memory port controller
package asp_pkg;
   typedef struct packed {
      logic sel_n;       // Active-low select
      logic sel;         // Active-high select
      logic out_en_n;    // Output enable, low active
      logic wr_n;        // Write strobe, low active
   } asp_ctrl_type;
   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] wdata;
      logic write;
   } asp_req_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD = 3'b001,
      ST_WR_SETUP = 3'b010,
      ST_WR = 3'b011,
      ST_GAP = 3'b100
   } asp_state_type;
endpackage

// >>> logic/asp_sync.sv
// Three-stage synchroniser for the data pins
`timescale 1ns/1ps
module asp_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,              // System clock
   input wire logic reset_i,            // Synchronous reset
   input wire logic [WIDTH-1:0] d_i,    // Asynchronous pin levels
   output logic [WIDTH-1:0] q_o         // Settled value
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   // Stage one feeds stage two only; a change counts when two and three agree
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q_o <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_o <= s3;
         end
      end
   end
endmodule // asp_sync

// >>> dv/asp_sram_model.sv
// Behavioural 128K x 8 static memory on the far side of the port
`timescale 1ns/1ps
module asp_sram_model (
   input wire logic sel_n_i, // Active-low select
   input wire logic sel_i, // Active-high select
   input wire logic out_en_n_i, // Output enable, low active
   input wire logic wr_n_i, // Write strobe, low active
   input wire logic [16:0] addr_i, // Address pins
   input wire logic [7:0] data_i, // Resolved data pins
   output logic [7:0] data_o, // Read drive value
   output logic drive_o // High while driving pins
);
   logic [7:0] mem [0:131071];
   // Deselect idles the array at once, no wake-up delay
   wire on = !sel_n_i && sel_i;
   wire wr = on && !wr_n_i;
   // Strobe low or deselect floats the pins
   assign drive_o = on && !out_en_n_i && wr_n_i;
   // Old byte kept 5 ns, then junk until the access time has run
   always @(drive_o or addr_i) begin
      data_o <= #5 ~data_o;
      if (drive_o) data_o <= #55 mem[addr_i];
   end
   // Stored when the overlap ends, whichever pin ends it
   always @(negedge wr) mem[addr_i] = data_i;
endmodule // asp_sram_model

// >>> dv/asp_ctrl_chk.sv
// Pin and handshake checks for the memory port controller
`timescale 1ns/1ps
module asp_ctrl_chk #(
   parameter bit SLOW_GRADE = 1'b0
) (
   input wire logic clk_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic req_valid_i, // Request
   input wire logic req_write_i, // Write flag
   input wire logic [16:0] req_addr_i, // Request address
   input wire logic req_ready_o, // Ready
   input wire logic rsp_valid_o, // Done pulse
   input wire logic [16:0] mem_addr_o, // Address pins
   input wire logic mem_sel_n_o, // Select low
   input wire logic mem_sel_o, // Select high
   input wire logic mem_out_en_n_o, // Output enable
   input wire logic mem_wr_n_o, // Strobe
   input wire logic [7:0] mem_data_o, // Drive value
   input wire logic mem_data_oe_o // Drive enable
);
   // Answer delays run from the take edge to the edge that sees the pulse
   localparam int RDL = SLOW_GRADE ? 23 : 19;
   localparam int WRL = SLOW_GRADE ? 17 : 14;
   localparam int SCE = SLOW_GRADE ? 15 : 12;
   wire take = req_valid_i && req_ready_o; // Request taken
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_rd_latency: assert property (
      take && !req_write_i |-> ##RDL rsp_valid_o)
      else $error("read answer not on time");
   a_wr_latency: assert property (
      take && req_write_i |-> ##WRL rsp_valid_o)
      else $error("write answer not on time");
   a_addr_first: assert property (
      take |=> mem_addr_o == $past(req_addr_i) && !mem_sel_n_o && mem_sel_o)
      else $error("address late");
   a_addr_hold: assert property (
      !mem_sel_n_o && !$past(mem_sel_n_o) |-> $stable(mem_addr_o))
      else $error("address moved");
   a_wr_selected: assert property (
      !mem_wr_n_o |-> !mem_sel_n_o && mem_sel_o)
      else $error("strobe outside select");
   a_rd_mode: assert property (
      !mem_out_en_n_o |-> mem_wr_n_o && !mem_data_oe_o && !mem_sel_n_o)
      else $error("output enable during a write");
   a_sel_setup: assert property (
      $rose(mem_wr_n_o) |-> !$past(mem_sel_n_o, SCE))
      else $error("select too short");
   a_data_hold: assert property (
      !mem_wr_n_o |-> mem_data_oe_o && $stable(mem_data_o))
      else $error("write data moved");
   c_read: cover property (take && !req_write_i);
   c_write: cover property (take && req_write_i);
   c_wr_end: cover property ($rose(mem_wr_n_o));
endmodule // asp_ctrl_chk
bind asp_ctrl asp_ctrl_chk #(.SLOW_GRADE(SLOW_GRADE)) chk_u (
   .clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
   .req_write_i(req_write_i), .req_addr_i(req_addr_i),
   .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
   .mem_addr_o(mem_addr_o), .mem_sel_n_o(mem_sel_n_o),
   .mem_sel_o(mem_sel_o), .mem_out_en_n_o(mem_out_en_n_o),
   .mem_wr_n_o(mem_wr_n_o), .mem_data_o(mem_data_o),
   .mem_data_oe_o(mem_data_oe_o));

// >>> dv/asp_ctrl_tb_top.sv
// Self-checking bench for the memory port controller
`timescale 1ns/1ps
module asp_ctrl_tb_top;
   logic clk_i = 0;
   logic reset_i = 1;
   logic v = 0;
   logic w = 0;
   logic [16:0] a = 0;
   logic [7:0] d = 0;
   wire rdy, rv, sn, s, oen, wn, doe, drv;
   wire [7:0] rd, mdo, mq, bus;
   wire [16:0] ma;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [8:0] notes [$]; // Read flag and expected byte
   logic [7:0] sh [int]; // Bytes the memory should hold
   logic [8:0] n;
   // Trace delay keeps the zero hold time at write end honest
   assign #0.5 bus = doe ? mdo : mq;
   initial forever #2 clk_i = ~clk_i;
   asp_ctrl dut_u (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(v),
      .req_write_i(w), .req_addr_i(a), .req_wdata_i(d), .req_ready_o(rdy),
      .rsp_valid_o(rv), .rsp_rdata_o(rd), .mem_addr_o(ma),
      .mem_sel_n_o(sn), .mem_sel_o(s), .mem_out_en_n_o(oen),
      .mem_wr_n_o(wn), .mem_data_i(bus), .mem_data_o(mdo),
      .mem_data_oe_o(doe));
   asp_sram_model mem_u (.sel_n_i(sn), .sel_i(s), .out_en_n_i(oen),
      .wr_n_i(wn), .addr_i(ma), .data_i(bus), .data_o(mq), .drive_o(drv));
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Request held from a falling edge until the rising edge that takes it
   task automatic acc(bit wr, logic [16:0] ad, logic [7:0] dt);
      int i;
      @(negedge clk_i);
      v <= 1;
      w <= wr;
      a <= ad;
      d <= dt;
      // Ready is looked at between edges, where it has settled
      for (i = 0; i < 300 && rdy !== 1'b1; i++) @(negedge clk_i);
      if (i == 300) begin
         n_mismatch++;
         conclude();
      end
      @(posedge clk_i);
      notes.push_back({!wr, wr ? dt : sh[ad]});
      if (wr) sh[ad] = dt;
      @(negedge clk_i);
      v <= 0;
   endtask
   // Answers are matched to requests in the order they were taken
   // The data pins are never driven from both ends at once
   always @(negedge clk_i) begin
      if (reset_i === 1'b0) begin
         check("bus fight", {7'h00, doe & drv}, 8'h00);
      end
      if (rv === 1'b1) begin
         if (notes.size() == 0) check("spurious answer", 8'h01, 8'h00);
         else begin
            n = notes.pop_front();
            if (n[8]) check("read byte", rd, n[7:0]);
         end
      end
   end
   initial begin
      void'($urandom(59595));
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      reset_i <= 0;
      // Both ends of the address range first, then random places
      acc(1, 17'h00000, 8'h5A);
      acc(1, 17'h1FFFF, 8'hA5);
      for (int k = 0; k < 16; k++) acc(1, 17'($urandom), 8'($urandom));
      acc(1, 17'h1FFFF, 8'h3C); // Overwrite leaves only the last byte
      // Reset in mid-run once the last write has answered; memory keeps data
      for (int i = 0; i < 300 && notes.size() > 0; i++) @(negedge clk_i);
      reset_i <= 1;
      repeat (4) @(negedge clk_i);
      check("ready in reset", {7'h00, rdy}, 8'h00);
      check("select in reset", {7'h00, sn}, 8'h01);
      reset_i <= 0;
      foreach (sh[k]) acc(0, 17'(k), 8'($urandom));
      for (int i = 0; i < 300 && notes.size() > 0; i++) @(posedge clk_i);
      if (notes.size() > 0) check("answers left", 8'h01, 8'h00);
      conclude();
   end
endmodule // asp_ctrl_tb_top
